// ===== dacq_map.svh
`ifndef DACQ_MAP_SVH
`define DACQ_MAP_SVH

// ==========================================
// sizes
`define DACQ_NCH 4
`define DACQ_AW 20
`define DACQ_CW 21
`define DACQ_DEPTH 21'h100000
`define DACQ_A1 20'h00001
`define DACQ_C1 21'h000001
`define DACQ_C0 21'h000000

// ==========================================
// bus address fields
`define DACQ_REG_BIT 23
`define DACQ_MCH_HI 22
`define DACQ_MCH_LO 21
`define DACQ_MIDX_HI 20
`define DACQ_MIDX_LO 1
`define DACQ_RCH_HI 6
`define DACQ_RCH_LO 5
`define DACQ_RIDX_HI 4
`define DACQ_RIDX_LO 2

// ==========================================
// register word indices inside a channel block
`define DACQ_OFS_CTRL 3'h0
`define DACQ_OFS_POINTS 3'h1
`define DACQ_OFS_PRETRIG 3'h2
`define DACQ_OFS_DELAY 3'h3
`define DACQ_OFS_RATE 3'h4
`define DACQ_OFS_STATUS 3'h5
`define DACQ_OFS_FIFO 3'h6

// ==========================================
// control and status fields
`define DACQ_CTRL_ARM 0
`define DACQ_CTRL_FORCE 1
`define DACQ_CTRL_MODE_HI 3
`define DACQ_CTRL_MODE_LO 2
`define DACQ_CTRL_SEL_HI 6
`define DACQ_CTRL_SEL_LO 4
`define DACQ_MODE_LIN 2'h0
`define DACQ_MODE_DEL 2'h1
`define DACQ_MODE_FIFO 2'h2
`define DACQ_SEL_EXT 3'h4
`define DACQ_ST_BUSY 0
`define DACQ_ST_DONE 1
`define DACQ_ST_THR 2
`define DACQ_ST_OVR 3
`define DACQ_ST_UND 4
`define DACQ_ST_FILL_LO 8

// ==========================================
// timing
`define DACQ_CLK_NS 25
`define DACQ_SAMP_NS 10000

`endif

// ===== dacq_pkg.sv
// ==========================================
// shared types
package dacq_pkg;
	// acquisition sequencer states
	typedef enum logic [2:0] {
		S_IDLE, S_WAIT, S_PRE, S_WATCH, S_DELAY, S_POST, S_FIFO, S_DONE
	} dacq_state_type;
	// one converter sample, two's complement
	typedef logic signed [15:0] dacq_sample_type;
endpackage

// ===== dacq_ctrl.sv
// Behaviour
// - arming starts sample clock, waits for trigger
// - disarm returns sequencer to idle, halts capture
// - trigger from external, channel comparator, force
// - any channel comparator selectable per channel
// - exactly one trigger source, no combining; force bit is ORed with the selected source
// - force bit triggers only its own channel
// - linear captures sample-count samples from trigger
// - sample zero at offset zero of region
// - nonzero pre-trigger count stores immediately when armed
// - after pre-count, watch trigger, store sample zero
// - post-trigger samples equal count minus pre-count
// - last pre-trigger sample at region top
// - delayed mode stores zero after delay periods
// - delayed mode post samples equal sample count
// - fifo mode circular buffer, overwrites oldest
// - threshold flag when stored equals sample count
// - threshold clears when unread below threshold
// - overrun flag when unread data overwritten
// - underrun flag when reading empty buffer
// - overrun, underrun cleared only by new acquisition
// - one 16-bit word per sample, consecutive
// - fifo read via fixed register, linear any address
`include "dacq_map.svh"

module dacq_ctrl (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// register port
	input wire logic [23:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [31:0] bus_rdata,
	// converter stream
	input wire dacq_pkg::dacq_sample_type adc_data [`DACQ_NCH],
	output logic [`DACQ_NCH-1:0] samp_tick,
	// trigger comparators
	input wire logic ext_trig,
	input wire logic [`DACQ_NCH-1:0] chan_trig,
	// channel state
	output logic [`DACQ_NCH-1:0] chan_busy
);
	import dacq_pkg::*;

	// ==========================================
	// helpers
	// rotate a host word index by the sample-zero location
	function automatic logic [`DACQ_AW-1:0] dacq_phys(
		input logic [`DACQ_AW-1:0] idx,
		input logic [`DACQ_AW-1:0] zero);
		dacq_phys = idx + zero;
	endfunction

	// samples to keep from sample zero onward
	function automatic logic [`DACQ_CW-1:0] dacq_target(
		input logic [1:0] m,
		input logic [`DACQ_CW-1:0] pts,
		input logic [`DACQ_CW-1:0] pre);
		if (m == `DACQ_MODE_LIN && pre != `DACQ_C0 && pts > pre)
			dacq_target = pts - pre;
		else if (m == `DACQ_MODE_LIN && pre != `DACQ_C0)
			dacq_target = `DACQ_C1;
		else
			dacq_target = pts;
	endfunction

	// ==========================================
	// declarations
	// synchronisers for pins
	dacq_sample_type adc_m [`DACQ_NCH];
	dacq_sample_type adc_s [`DACQ_NCH];
	logic [4:0] trg_m, trg_s, trg_d; // bit 4 external
	logic [4:0] trg_edge;
	// software registers
	logic [`DACQ_NCH-1:0] arm, next_arm;
	logic [1:0] mode [`DACQ_NCH];
	logic [1:0] next_mode [`DACQ_NCH];
	logic [2:0] sel [`DACQ_NCH];
	logic [2:0] next_sel [`DACQ_NCH];
	logic [`DACQ_CW-1:0] points [`DACQ_NCH];
	logic [`DACQ_CW-1:0] next_points [`DACQ_NCH];
	logic [`DACQ_CW-1:0] pretrig [`DACQ_NCH];
	logic [`DACQ_CW-1:0] next_pretrig [`DACQ_NCH];
	logic [`DACQ_CW-1:0] delay [`DACQ_NCH];
	logic [`DACQ_CW-1:0] next_delay [`DACQ_NCH];
	logic [15:0] rate [`DACQ_NCH];
	logic [15:0] next_rate [`DACQ_NCH];
	logic [`DACQ_NCH-1:0] force_pulse; // one-cycle force strobe
	logic [31:0] next_rdata; // register read value
	// bus decode
	logic reg_hit;
	logic [1:0] rch, mch;
	logic [2:0] ridx;
	logic [`DACQ_NCH-1:0] pop, pop_ok;
	// sequencer state
	dacq_state_type st [`DACQ_NCH];
	dacq_state_type next_st [`DACQ_NCH];
	logic [`DACQ_AW-1:0] wptr [`DACQ_NCH];
	logic [`DACQ_AW-1:0] next_wptr [`DACQ_NCH];
	logic [`DACQ_AW-1:0] zptr [`DACQ_NCH];
	logic [`DACQ_AW-1:0] next_zptr [`DACQ_NCH];
	logic [`DACQ_AW-1:0] rptr [`DACQ_NCH];
	logic [`DACQ_AW-1:0] next_rptr [`DACQ_NCH];
	logic [`DACQ_CW-1:0] cnt [`DACQ_NCH];
	logic [`DACQ_CW-1:0] next_cnt [`DACQ_NCH];
	logic [`DACQ_CW-1:0] fill [`DACQ_NCH];
	logic [`DACQ_CW-1:0] next_fill [`DACQ_NCH];
	logic [15:0] div [`DACQ_NCH];
	logic [15:0] next_div [`DACQ_NCH];
	logic [`DACQ_NCH-1:0] pend, next_pend; // latched trigger
	logic [`DACQ_NCH-1:0] thr, next_thr;
	logic [`DACQ_NCH-1:0] ovr, next_ovr;
	logic [`DACQ_NCH-1:0] und, next_und;
	logic [`DACQ_NCH-1:0] tick, sel_edge, zero_evt;
	logic [`DACQ_NCH-1:0] mem_we;
	logic [`DACQ_AW-1:0] mem_wa [`DACQ_NCH];
	logic [`DACQ_CW-1:0] tgt [`DACQ_NCH];
	// channel sample memories
	dacq_sample_type mem [`DACQ_NCH][`DACQ_DEPTH];

	// ==========================================
	// pin synchronisers
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			trg_m <= 5'h00;
			trg_s <= 5'h00;
			trg_d <= 5'h00;
			for (int c = 0; c < `DACQ_NCH; c++)
			begin
				adc_m[c] <= 16'sh0000;
				adc_s[c] <= 16'sh0000;
			end
		end
		else
		begin
			trg_m <= {ext_trig, chan_trig};
			trg_s <= trg_m;
			trg_d <= trg_s;
			for (int c = 0; c < `DACQ_NCH; c++)
			begin
				adc_m[c] <= adc_data[c];
				adc_s[c] <= adc_m[c];
			end
		end
	end

	// rising edges of synchronised comparator outputs
	assign trg_edge = trg_s & ~trg_d;

	// ==========================================
	// bus decode
	assign reg_hit = bus_addr[`DACQ_REG_BIT];
	assign rch = bus_addr[`DACQ_RCH_HI:`DACQ_RCH_LO];
	assign ridx = bus_addr[`DACQ_RIDX_HI:`DACQ_RIDX_LO];
	assign mch = bus_addr[`DACQ_MCH_HI:`DACQ_MCH_LO];

	// ==========================================
	// software register group
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		force_pulse = '0;
		for (int c = 0; c < `DACQ_NCH; c++)
		begin
			next_arm[c] = arm[c];
			next_mode[c] = mode[c];
			next_sel[c] = sel[c];
			next_points[c] = points[c];
			next_pretrig[c] = pretrig[c];
			next_delay[c] = delay[c];
			next_rate[c] = rate[c];
			pop[c] = bus_rd && reg_hit && rch == 2'(c)
				&& ridx == `DACQ_OFS_FIFO;
			// register writes
			if (bus_wr && reg_hit && rch == 2'(c))
			begin
				case (ridx)
					`DACQ_OFS_CTRL:
					begin
						next_arm[c] = bus_wdata[`DACQ_CTRL_ARM];
						force_pulse[c] = bus_wdata[`DACQ_CTRL_FORCE];
						next_mode[c] = bus_wdata[`DACQ_CTRL_MODE_HI:`DACQ_CTRL_MODE_LO];
						next_sel[c] = bus_wdata[`DACQ_CTRL_SEL_HI:`DACQ_CTRL_SEL_LO];
					end
					`DACQ_OFS_POINTS: next_points[c] = bus_wdata[`DACQ_CW-1:0];
					`DACQ_OFS_PRETRIG: next_pretrig[c] = bus_wdata[`DACQ_CW-1:0];
					`DACQ_OFS_DELAY: next_delay[c] = bus_wdata[`DACQ_CW-1:0];
					`DACQ_OFS_RATE: next_rate[c] = bus_wdata[15:0];
					default: ; // read-only or unmapped
				endcase
			end
			// register reads
			if (bus_rd && reg_hit && rch == 2'(c))
			begin
				case (ridx)
					`DACQ_OFS_CTRL: next_rdata = {25'h0, sel[c], mode[c],
						1'b0, arm[c]};
					`DACQ_OFS_POINTS: next_rdata = {11'h0, points[c]};
					`DACQ_OFS_PRETRIG: next_rdata = {11'h0, pretrig[c]};
					`DACQ_OFS_DELAY: next_rdata = {11'h0, delay[c]};
					`DACQ_OFS_RATE: next_rdata = {16'h0, rate[c]};
					`DACQ_OFS_STATUS: next_rdata = {3'h0, fill[c], 3'h0,
						und[c], ovr[c], thr[c], st[c] == S_DONE, chan_busy[c]};
					default: next_rdata = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			arm <= '0;
			for (int c = 0; c < `DACQ_NCH; c++)
			begin
				mode[c] <= `DACQ_MODE_LIN;
				sel[c] <= `DACQ_SEL_EXT;
				points[c] <= `DACQ_C1;
				pretrig[c] <= `DACQ_C0;
				delay[c] <= `DACQ_C0;
				rate[c] <= 16'(`DACQ_SAMP_NS / `DACQ_CLK_NS);
			end
		end
		else
		begin
			arm <= next_arm;
			mode <= next_mode;
			sel <= next_sel;
			points <= next_points;
			pretrig <= next_pretrig;
			delay <= next_delay;
			rate <= next_rate;
		end
	end

	// ==========================================
	// sequencer group: divider, trigger, pointers, flags
	always_comb
	begin
		for (int c = 0; c < `DACQ_NCH; c++)
		begin
			next_st[c] = st[c];
			next_wptr[c] = wptr[c];
			next_zptr[c] = zptr[c];
			next_rptr[c] = rptr[c];
			next_cnt[c] = cnt[c];
			next_fill[c] = fill[c];
			next_ovr[c] = ovr[c];
			next_und[c] = und[c];
			next_thr[c] = thr[c];
			mem_we[c] = 1'b0;
			mem_wa[c] = wptr[c];
			zero_evt[c] = 1'b0;
			pop_ok[c] = 1'b0;
			tgt[c] = dacq_target(mode[c], points[c], pretrig[c]);
			// sample clock runs only while armed and neither idle nor done
			tick[c] = 1'b0;
			next_div[c] = 16'h0000;
			if (arm[c] && st[c] != S_IDLE && st[c] != S_DONE)
			begin
				tick[c] = {1'b0, div[c]} + 17'h00001 >= {1'b0, rate[c]};
				next_div[c] = tick[c] ? 16'h0000 : div[c] + 16'h0001;
			end
			// the selected source and the force bit feed the trigger latch
			sel_edge[c] = (sel[c] == `DACQ_SEL_EXT) ? trg_edge[4] :
				(sel[c] < `DACQ_SEL_EXT) ? trg_edge[sel[c][1:0]] : 1'b0;
			next_pend[c] = (st[c] == S_WAIT || st[c] == S_WATCH)
				&& (pend[c] || sel_edge[c] || force_pulse[c]);
			case (st[c])
				S_IDLE:
				begin
					if (arm[c])
					begin
						// new acquisition: clear pointers and fifo flags
						next_ovr[c] = 1'b0;
						next_und[c] = 1'b0;
						next_thr[c] = 1'b0;
						next_wptr[c] = '0;
						next_zptr[c] = '0;
						next_rptr[c] = '0;
						next_cnt[c] = `DACQ_C0;
						next_fill[c] = `DACQ_C0;
						if (mode[c] == `DACQ_MODE_LIN && pretrig[c] != `DACQ_C0)
							next_st[c] = S_PRE;
						else
							next_st[c] = S_WAIT;
					end
				end
				S_WAIT:
				begin
					if (tick[c] && pend[c])
					begin
						next_pend[c] = 1'b0;
						if (mode[c] == `DACQ_MODE_FIFO)
							next_st[c] = S_FIFO;
						else
						begin
							mem_we[c] = 1'b1;
							next_wptr[c] = wptr[c] + `DACQ_A1;
							next_cnt[c] = `DACQ_C1;
							if (mode[c] == `DACQ_MODE_DEL && delay[c] != `DACQ_C0)
								next_st[c] = S_DELAY;
							else
							begin
								zero_evt[c] = 1'b1;
								next_zptr[c] = wptr[c];
								next_st[c] = (tgt[c] <= `DACQ_C1) ? S_DONE : S_POST;
							end
						end
					end
				end
				S_PRE:
				begin
					if (tick[c])
					begin
						// pre-trigger samples wrap through the region
						mem_we[c] = 1'b1;
						next_wptr[c] = wptr[c] + `DACQ_A1;
						next_cnt[c] = cnt[c] + `DACQ_C1;
						if (cnt[c] + `DACQ_C1 >= pretrig[c])
							next_st[c] = S_WATCH;
					end
				end
				S_WATCH:
				begin
					if (tick[c])
					begin
						mem_we[c] = 1'b1;
						next_wptr[c] = wptr[c] + `DACQ_A1;
						if (pend[c])
						begin
							// zero rotates the view: last pre sample lands on top
							zero_evt[c] = 1'b1;
							next_pend[c] = 1'b0;
							next_zptr[c] = wptr[c];
							next_cnt[c] = `DACQ_C1;
							next_st[c] = (tgt[c] <= `DACQ_C1) ? S_DONE : S_POST;
						end
					end
				end
				S_DELAY:
				begin
					if (tick[c])
					begin
						mem_we[c] = 1'b1;
						next_wptr[c] = wptr[c] + `DACQ_A1;
						if (cnt[c] >= delay[c])
						begin
							zero_evt[c] = 1'b1;
							next_zptr[c] = wptr[c];
							next_cnt[c] = `DACQ_C1;
							next_st[c] = (tgt[c] <= `DACQ_C1) ? S_DONE : S_POST;
						end
						else
							next_cnt[c] = cnt[c] + `DACQ_C1;
					end
				end
				S_POST:
				begin
					if (tick[c])
					begin
						mem_we[c] = 1'b1;
						next_wptr[c] = wptr[c] + `DACQ_A1;
						next_cnt[c] = cnt[c] + `DACQ_C1;
						if (cnt[c] + `DACQ_C1 >= tgt[c])
							next_st[c] = S_DONE;
					end
				end
				S_FIFO:
				begin
					if (tick[c])
					begin
						mem_we[c] = 1'b1;
						next_wptr[c] = wptr[c] + `DACQ_A1;
						if (fill[c] == `DACQ_DEPTH)
						begin
							// oldest unread word lost
							next_ovr[c] = 1'b1;
							next_rptr[c] = rptr[c] + `DACQ_A1;
						end
						else
							next_fill[c] = fill[c] + `DACQ_C1;
					end
				end
				S_DONE: ;
				default: next_st[c] = S_IDLE;
			endcase
			// host pops from the fixed fifo word
			if (pop[c] && mode[c] == `DACQ_MODE_FIFO
				&& (st[c] == S_WAIT || st[c] == S_FIFO))
			begin
				if (fill[c] == `DACQ_C0)
					next_und[c] = 1'b1;
				else
				begin
					pop_ok[c] = 1'b1;
					next_fill[c] = next_fill[c] - `DACQ_C1;
					next_rptr[c] = next_rptr[c] + `DACQ_A1;
				end
			end
			// threshold: set on reaching count wins over a read clear
			if (st[c] == S_FIFO)
			begin
				if (pop_ok[c] && next_fill[c] < points[c])
					next_thr[c] = 1'b0;
				if (mem_we[c] && next_fill[c] == points[c])
					next_thr[c] = 1'b1;
			end
			// disarm aborts everything
			if (!arm[c])
			begin
				next_st[c] = S_IDLE;
				next_pend[c] = 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			pend <= '0;
			thr <= '0;
			ovr <= '0;
			und <= '0;
			samp_tick <= '0;
			chan_busy <= '0;
			for (int c = 0; c < `DACQ_NCH; c++)
			begin
				st[c] <= S_IDLE;
				wptr[c] <= '0;
				zptr[c] <= '0;
				rptr[c] <= '0;
				cnt[c] <= `DACQ_C0;
				fill[c] <= `DACQ_C0;
				div[c] <= 16'h0000;
			end
		end
		else
		begin
			pend <= next_pend;
			thr <= next_thr;
			ovr <= next_ovr;
			und <= next_und;
			samp_tick <= tick;
			for (int c = 0; c < `DACQ_NCH; c++)
				chan_busy[c] <= next_st[c] != S_IDLE && next_st[c] != S_DONE;
			st <= next_st;
			wptr <= next_wptr;
			zptr <= next_zptr;
			rptr <= next_rptr;
			cnt <= next_cnt;
			fill <= next_fill;
			div <= next_div;
		end
	end

	// ==========================================
	// sample memories and read data
	always_ff @(posedge mclk)
	begin
		for (int c = 0; c < `DACQ_NCH; c++)
			if (mem_we[c])
				mem[c][mem_wa[c]] <= adc_s[c];
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			bus_rdata <= 32'h0000_0000;
		else if (bus_rd && !reg_hit)
			// any word of the region, seen relative to sample zero
			bus_rdata <= {{16{1'b0}}, mem[mch][dacq_phys(
				bus_addr[`DACQ_MIDX_HI:`DACQ_MIDX_LO], zptr[mch])]};
		else if (|pop_ok)
			bus_rdata <= {{16{1'b0}}, mem[rch][rptr[rch]]};
		else
			bus_rdata <= next_rdata;
	end

	// ==========================================
	// checks on channel 0
	default clocking dacq_cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	sequence s_start_pre;
		st[0] == S_IDLE && arm[0] && mode[0] == `DACQ_MODE_LIN
			&& pretrig[0] != `DACQ_C0;
	endsequence
	sequence s_fifo_full_write;
		st[0] == S_FIFO && tick[0] && fill[0] == `DACQ_DEPTH;
	endsequence

	chk_disarm_idle: assert property (!arm[0] |=> st[0] == S_IDLE)
		else $error("disarmed channel not idle");
	chk_wait_no_store: assert property (
		(st[0] == S_WAIT && mem_we[0]) |-> pend[0])
		else $error("sample stored without trigger");
	chk_pre_at_once: assert property (s_start_pre |=> st[0] == S_PRE)
		else $error("pre-trigger capture did not start");
	chk_zero_pointer: assert property (
		zero_evt[0] |=> zptr[0] == $past(wptr[0]))
		else $error("sample zero not at offset zero");
	chk_force_local: assert property (
		(force_pulse[0] && !force_pulse[1] && !pend[1] && !sel_edge[1])
		|=> !pend[1])
		else $error("force leaked to another channel");
	chk_pend_cause: assert property (
		$rose(pend[0]) |-> $past(sel_edge[0]) || $past(force_pulse[0]))
		else $error("trigger from unselected source");
	chk_post_end: assert property (
		(st[0] == S_POST && tick[0] && cnt[0] + `DACQ_C1 >= tgt[0] && arm[0])
		|=> st[0] == S_DONE ##1 !mem_we[0])
		else $error("capture length wrong");
	chk_ovr_set: assert property (s_fifo_full_write ##0 arm[0] |=> ovr[0])
		else $error("overrun not flagged");
	chk_ovr_sticky: assert property (
		(ovr[0] && st[0] != S_IDLE) |=> ovr[0])
		else $error("overrun cleared during capture");
	chk_und_set: assert property (
		(pop[0] && mode[0] == `DACQ_MODE_FIFO && st[0] == S_FIFO
		&& fill[0] == `DACQ_C0 && arm[0]) |=> und[0])
		else $error("underrun not flagged");
	chk_thr_set: assert property (
		(st[0] == S_FIFO && mem_we[0] && next_fill[0] == points[0] && arm[0])
		|=> thr[0])
		else $error("threshold not raised");
endmodule

// ===== dacq_adc_model.sv
// ==========================================
// converter stream model
// each channel holds a ramp that steps once per convert strobe, so
// stored samples can be checked by their order alone
module dacq_adc_model
	import dacq_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// convert strobes from the sequencer
	input wire logic [3:0] samp_tick,
	// converter pins per channel
	output dacq_sample_type adc_data [4]
);
	timeunit 1ns;
	timeprecision 1ps;
	// ramp steps only on a strobe, held between strobes like a real
	// converter output register
	always_ff @(posedge mclk or negedge resetn)
	begin
		for (int c = 0; c < 4; c++)
		begin
			if (!resetn)
				adc_data[c] <= dacq_sample_type'(c * 16'h1000);
			else if (samp_tick[c])
				adc_data[c] <= adc_data[c] + 16'sh0001;
		end
	end
endmodule

// ===== dacq_tb.sv
// ==========================================
// acquisition sequencer testbench
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import dacq_pkg::*;
	// clock, reset and bus
	logic mclk;
	logic resetn;
	logic [23:0] bus_addr;
	logic [31:0] bus_wdata;
	logic bus_wr;
	logic bus_rd;
	logic [31:0] bus_rdata;
	// stream and triggers
	dacq_sample_type adc_data [4];
	logic [3:0] samp_tick;
	logic ext_trig;
	logic [3:0] chan_trig;
	logic [3:0] chan_busy;
	int num_errors = 0;
	int total_checks = 0;
	logic [31:0] d;
	logic [31:0] v0;

	// ==========================================
	// instances
	dacq_ctrl uut (.mclk(mclk), .resetn(resetn), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_rdata(bus_rdata), .adc_data(adc_data), .samp_tick(samp_tick),
		.ext_trig(ext_trig), .chan_trig(chan_trig), .chan_busy(chan_busy));
	dacq_adc_model adc (.mclk(mclk), .resetn(resetn),
		.samp_tick(samp_tick), .adc_data(adc_data));

	// free running clock
	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// ==========================================
	// bus tasks
	// register byte address of a channel word
	function automatic logic [23:0] ra(input int ch, input int idx);
		return 24'h800000 + 24'(ch * 32) + 24'(idx * 4);
	endfunction

	task automatic bw(input logic [23:0] a, input logic [31:0] w);
		@(posedge mclk);
		bus_addr <= a;
		bus_wdata <= w;
		bus_wr <= 1'b1;
		@(posedge mclk);
		bus_wr <= 1'b0;
	endtask

	// data stand in the cycle after the strobe only
	task automatic br(input logic [23:0] a, output logic [31:0] r);
		@(posedge mclk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge mclk);
		bus_rd <= 1'b0;
		#1;
		r = bus_rdata;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		// an unknown expectation would match an unknown reading
		if (got !== exp || $isunknown(exp))
		begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// read a word and compare it
	task automatic rchk(input logic [23:0] a, input logic [31:0] exp);
		logic [31:0] r;
		br(a, r);
		chk(r, exp);
	endtask

	// did the convert strobe of a channel pulse within 8 cycles
	task automatic tick_seen(input int ch, output logic [31:0] s);
		s = 32'h0;
		repeat (8)
		begin
			@(posedge mclk);
			s = s | 32'(samp_tick[ch]);
		end
	endtask

	// poll one status bit under a bound
	task automatic wait_st(input int ch, input int b, input logic val);
		logic [31:0] r;
		for (int i = 0; i < 3000; i++)
		begin
			br(ra(ch, 5), r);
			if (r[b] === val)
				return;
		end
		num_errors++;
		$display("wait for status bit ran out at %0t", $time);
		wrap_up();
	endtask

	// program counts and rate, then arm
	task automatic setup(input int ch, input int mode, input int sel,
		input int pts, input int pre, input int dly, input int rate);
		bw(ra(ch, 1), 32'(pts));
		bw(ra(ch, 2), 32'(pre));
		bw(ra(ch, 3), 32'(dly));
		bw(ra(ch, 4), 32'(rate));
		bw(ra(ch, 0), 32'(sel * 16 + mode * 4 + 1));
	endtask

	task automatic force_trig(input int ch, input int mode, input int sel);
		bw(ra(ch, 0), 32'(sel * 16 + mode * 4 + 3));
	endtask

	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ==========================================
	// scenarios
	task automatic t_reset;
		rchk(ra(0, 1), 32'h00000001);
		rchk(ra(0, 4), 32'h00000190);
		rchk(ra(0, 5), 32'h00000000);
		rchk(ra(0, 7), 32'h00000000);
		$display("reset values done");
	endtask

	// armed with no trigger waits, force then captures in order
	task automatic t_linear;
		setup(0, 0, 5, 5, 0, 0, 4);
		repeat (40) @(posedge mclk);
		br(ra(0, 5), d);
		chk(d & 32'h3, 32'h1);
		force_trig(0, 0, 5);
		wait_st(0, 1, 1'b1);
		chk(32'(chan_busy[0]), 32'h0);
		br(24'h000000, v0);
		for (int i = 1; i < 5; i++)
			rchk(24'(i * 2), {16'h0, v0[15:0] + 16'(i)});
		rchk(ra(0, 6), 32'h0);
		$display("linear capture done");
	endtask

	// pre-trigger samples sit under the top of the region
	task automatic t_pre;
		setup(1, 0, 5, 8, 3, 0, 4);
		repeat (60) @(posedge mclk);
		br(ra(1, 5), d);
		chk(d & 32'h3, 32'h1);
		force_trig(1, 0, 5);
		wait_st(1, 1, 1'b1);
		br(24'h200000, v0);
		for (int i = 1; i < 5; i++)
			rchk(24'h200000 + 24'(i * 2), {16'h0, v0[15:0] + 16'(i)});
		rchk(24'h3ffffe, {16'h0, v0[15:0] - 16'h1});
		rchk(24'h3ffffc, {16'h0, v0[15:0] - 16'h2});
		$display("pre-trigger capture done");
	endtask

	// delay kept well below the memory depth by software
	task automatic t_delay;
		setup(2, 1, 5, 4, 0, 3, 4);
		force_trig(2, 1, 5);
		wait_st(2, 1, 1'b1);
		br(24'h400000, v0);
		for (int i = 1; i < 4; i++)
			rchk(24'h400000 + 24'(i * 2), {16'h0, v0[15:0] + 16'(i)});
		rchk(24'h5ffffe, {16'h0, v0[15:0] - 16'h1});
		$display("delayed capture done");
	endtask

	// force, external and channel comparator each reach one channel
	task automatic t_select;
		bw(ra(0, 0), 32'h0);
		setup(3, 0, 0, 2, 0, 0, 4);
		setup(0, 0, 5, 2, 0, 0, 4);
		force_trig(0, 0, 5);
		wait_st(0, 1, 1'b1);
		br(ra(3, 5), d);
		chk(d & 32'h3, 32'h1);
		bw(ra(0, 0), 32'h0);
		setup(0, 0, 4, 2, 0, 0, 4);
		ext_trig <= 1'b1;
		repeat (8) @(posedge mclk);
		ext_trig <= 1'b0;
		wait_st(0, 1, 1'b1);
		br(ra(3, 5), d);
		chk(d & 32'h3, 32'h1);
		chan_trig[0] <= 1'b1;
		repeat (8) @(posedge mclk);
		chan_trig[0] <= 1'b0;
		wait_st(3, 1, 1'b1);
		$display("trigger select done");
	endtask

	// disarm in mid capture, after a pre-trigger start on channel 0
	task automatic t_abort;
		logic [31:0] s;
		bw(ra(0, 0), 32'h0);
		setup(0, 0, 5, 100, 2, 0, 4);
		repeat (20) @(posedge mclk);
		force_trig(0, 0, 5);
		repeat (20) @(posedge mclk);
		br(ra(0, 5), d);
		chk(d & 32'h3, 32'h1);
		tick_seen(0, s);
		chk(s, 32'h1);
		bw(ra(0, 0), 32'h0);
		// strobe launched by the last armed cycle may still show
		@(posedge mclk);
		tick_seen(0, s);
		chk(s, 32'h0);
		chk(32'(chan_busy[0]), 32'h0);
		br(ra(0, 5), d);
		chk(d & 32'h3, 32'h0);
		$display("disarm done");
	endtask

	// circular buffer flags
	task automatic t_fifo;
		bw(ra(0, 0), 32'h0);
		setup(0, 2, 5, 4, 0, 0, 40);
		force_trig(0, 2, 5);
		wait_st(0, 2, 1'b1);
		br(ra(0, 5), d);
		chk(32'(d[28:8]), 32'h4);
		br(ra(0, 6), v0);
		br(ra(0, 5), d);
		chk(32'(d[2]), 32'h0);
		for (int i = 1; i < 4; i++)
			rchk(ra(0, 6), {16'h0, v0[15:0] + 16'(i)});
		br(ra(0, 6), d);
		br(ra(0, 5), d);
		chk(32'(d[4]), 32'h1);
		br(ra(0, 5), d);
		chk(32'(d[4]), 32'h1);
		bw(ra(0, 0), 32'h0);
		setup(0, 2, 5, 4, 0, 0, 40);
		br(ra(0, 5), d);
		chk(32'(d[4:3]), 32'h0);
		$display("fifo flags done");
	endtask

	// ==========================================
	// main sequence
	initial
	begin
		resetn = 1'b0;
		bus_addr = 24'h0;
		bus_wdata = 32'h0;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		ext_trig = 1'b0;
		chan_trig = 4'h0;
		repeat (4) @(posedge mclk);
		resetn <= 1'b1;
		t_reset();
		t_linear();
		t_pre();
		t_delay();
		t_select();
		t_abort();
		t_fifo();
		wrap_up();
	end
endmodule
